// ---- rtl/fsi_pkg.sv ----
// Notes on behaviour
// - both channels of a dual-channel safety input are compared all the time and must carry the same level.
// - a channel disagreement is tolerated for up to the configured tolerance time (reset 500 ms), longer is a fault.
// - torque-off is selected as soon as either channel falls, without waiting for the tolerance time.
// - each safety input is debounced so that level changes shorter than the debounce time (reset 1 ms) are ignored.
// - a qualified input change reaches the logic on the debounce-th microsecond tick after it, up to one microsecond before the full debounce time.
// - too many level changes on a safety input within a monitoring interval raise a fault.
// - the safety debounce setting and the plain input debounce setting are independent of each other.
// - the torque-off active status bit reads 1 while torque-off is in effect.
// - every selection of torque-off runs the forced self-test of the switch-off paths and the brake relay if fitted; the code starts no test while one runs.
// - the interval between self-tests is timed against the monitoring time (reset 8 h) and the time left is readable.
// - status bit 31 goes to 1 to request a forced self-test once the monitoring time has elapsed.
// - safety enable value 0 disables all safety functions, value 1 enables the basic functions via terminals.
// - passwords 1 to FFFF FFFF are accepted and the reset value 0 means no password is set.
// - safety settings can be written only while the commissioning filter holds 95.
package fsi_pkg;
    // time base: microsecond tick derived from the 125 MHz clock
    localparam int CLK_PERIOD_PS = 8000;
    localparam int US_PS = 1000000;
    localparam int US_CYCLES = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MS_PER_S = 1000;
    localparam int US_PER_MS = 1000;

    // register byte offsets
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PASSWORD = 8'h04;
    localparam logic [7:0] OFS_FILTER = 8'h08;
    localparam logic [7:0] OFS_TOL = 8'h0c;
    localparam logic [7:0] OFS_SAFE_DEB = 8'h10;
    localparam logic [7:0] OFS_PLAIN_DEB = 8'h14;
    localparam logic [7:0] OFS_INTERVAL = 8'h18;
    localparam logic [7:0] OFS_TIME_LEFT = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_CTRL = 8'h2c;

    // reset values, plus the ENABLE_BASIC and FILTER_SAFETY codes
    localparam logic [3:0] ENABLE_NONE = 4'h0;
    localparam logic [3:0] ENABLE_BASIC = 4'h1;
    localparam logic [31:0] PASSWORD_NONE = 32'h0000_0000;
    localparam logic [7:0] FILTER_READY = 8'h00;
    localparam logic [7:0] FILTER_SAFETY = 8'h5f;
    localparam logic [15:0] TOL_MS_RST = 16'h01f4;
    localparam logic [15:0] SAFE_DEB_US_RST = 16'h03e8;
    localparam logic [15:0] PLAIN_DEB_US_RST = 16'h03e8;
    localparam logic [31:0] INTERVAL_S_RST = 32'h0000_7080;

    // toggle monitor and self-test timing
    localparam logic [15:0] TOGGLE_WIN_MS = 16'h03e8;
    localparam logic [7:0] TOGGLE_MAX = 8'h10;
    localparam logic [15:0] TEST_SETTLE_US = 16'h000a;

    // status register bits
    localparam int ST_PW_SET = 0;
    localparam int ST_TO_ACTIVE = 1;
    localparam int ST_MISMATCH = 2;
    localparam int ST_TOGGLE = 3;
    localparam int ST_TEST_FAIL = 4;
    localparam int ST_TESTING = 5;
    localparam int ST_REQUEST = 31;

    // interrupt bits
    localparam int IRQ_W = 5;
    localparam int IRQ_MISMATCH = 0;
    localparam int IRQ_TOGGLE = 1;
    localparam int IRQ_TO_SEL = 2;
    localparam int IRQ_REQUEST = 3;
    localparam int IRQ_TEST_FAIL = 4;

    // control register bits
    localparam int CTRL_ACK = 0;
    localparam int CTRL_BRAKE = 1;

    typedef enum logic [2:0] {
        TEST_IDLE = 3'b001,
        TEST_DRIVE = 3'b010,
        TEST_CHECK = 3'b100
    } test_state_e;
endpackage

// ---- rtl/timebase_if.sv ----
`timescale 1ns/1ps
interface timebase_if;
    logic us_tick;
    logic ms_tick;
    logic s_tick;
    modport src (output us_tick, output ms_tick, output s_tick);
    modport snk (input us_tick, input ms_tick, input s_tick);
endinterface

// ---- rtl/deb_filter.sv ----
`timescale 1ns/1ps
module deb_filter
    import fsi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    timebase_if.snk tb,
    input wire logic raw,
    input wire logic [15:0] deb_us,
    output logic filt,
    output logic toggle_fault
);
    logic [15:0] cnt_q;
    logic [15:0] win_q;
    logic [7:0] edges_q;
    logic raw_q;
    logic differ;
    logic qualified;
    logic raw_edge;
    logic win_end;

    assign differ = raw != filt;
    assign qualified = differ && tb.us_tick && (cnt_q + 16'h0001 >= deb_us);
    assign raw_edge = raw != raw_q;
    assign win_end = tb.ms_tick && (win_q == TOGGLE_WIN_MS - 16'h0001);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            filt <= 1'b0;
            cnt_q <= 16'h0000;
            raw_q <= 1'b0;
            win_q <= 16'h0000;
            edges_q <= 8'h00;
            toggle_fault <= 1'b0;
        end
        else
        begin
            raw_q <= raw;
            // timer restarts whenever the raw level returns to the filtered one
            cnt_q <= !differ || qualified ? 16'h0000 : cnt_q + {15'h0000, tb.us_tick};
            if (qualified)
                filt <= raw;
            win_q <= win_end ? 16'h0000 : win_q + {15'h0000, tb.ms_tick};
            edges_q <= win_end ? 8'h00 : (raw_edge && edges_q != 8'hff ? edges_q + 8'h01 : edges_q);
            toggle_fault <= raw_edge && (edges_q >= TOGGLE_MAX);
        end
    end
endmodule

// ---- rtl/selftest_timer.sv ----
`timescale 1ns/1ps
module selftest_timer
    import fsi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    timebase_if.snk tb,
    input wire logic enabled,
    input wire logic done,
    input wire logic [31:0] interval,
    output logic [31:0] time_left,
    output logic request
);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            time_left <= INTERVAL_S_RST;
            request <= 1'b0;
        end
        else if (!enabled || done)
        begin
            time_left <= interval;
            request <= 1'b0;
        end
        else
        begin
            if (tb.s_tick && time_left != 32'h0000_0000)
                time_left <= time_left - 32'h0000_0001;
            if (time_left == 32'h0000_0000)
                request <= 1'b1;
        end
    end
endmodule

// ---- rtl/failsafe_input_filter_test_timer.sv ----
`timescale 1ns/1ps
module failsafe_input_filter_test_timer
    import fsi_pkg::*;
#(
    parameter int US_PER_MS_P = US_PER_MS,
    parameter int MS_PER_S_P = MS_PER_S
)
(
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pins
    input wire logic [1:0] dual_channel_safety_input,
    input wire logic plain_input,
    input wire logic switch_off_feedback,
    input wire logic brake_relay_feedback,
    output logic plain_input_filtered,
    output logic torque_off_function,
    output logic torque_off_active_flag,
    output logic selftest_request_flag,
    output logic selftest_drive,
    output logic irq
);
    timebase_if tb ();

    logic [3:1] sync_1_q;
    logic [3:1] sync_2_q;
    logic [6:0] us_div_q;
    logic [9:0] ms_div_q;
    logic [9:0] s_div_q;
    logic us_tick_q;
    logic ms_tick_q;
    logic s_tick_q;

    logic [3:0] safety_enable_select_q;
    logic [31:0] safety_password_entry_q;
    logic [7:0] commissioning_filter_q;
    logic [15:0] channel_mismatch_tolerance_q;
    logic [15:0] safety_input_debounce_q;
    logic [15:0] plain_input_debounce_q;
    logic [31:0] selftest_interval_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic brake_present_q;

    logic [1:0] ch_filt;
    logic [1:0] ch_toggle;
    logic plain_filt;
    logic [1:0] ch_filt_q;
    logic [15:0] mis_ms_q;
    logic mismatch_fault_q;
    logic toggle_fault_q;
    logic test_fail_q;
    logic to_q;
    logic to_d;
    test_state_e test_q;
    test_state_e test_d;
    logic [15:0] test_us_q;
    logic [31:0] time_left;
    logic request;
    logic [31:0] rdata_d;

    // bus decode
    logic access;
    logic wr;
    logic safety_wr;
    logic ack_wr;
    logic [IRQ_W-1:0] irq_set;
    logic enabled;
    logic any_fall;
    logic mismatch;
    logic mis_expire;
    logic test_done;
    logic test_bad;
    logic paths_off;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = addr == ofs;
    endfunction

    assign access = (avs_read || avs_write) && avs_waitrequest;
    assign wr = access && avs_write;
    assign safety_wr = wr && (commissioning_filter_q == FILTER_SAFETY);
    assign ack_wr = wr && hit(avs_address, OFS_CTRL) && avs_writedata[CTRL_ACK];
    assign enabled = safety_enable_select_q == ENABLE_BASIC;

    // input synchronisers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync_1_q <= 3'h0;
            sync_2_q <= 3'h0;
        end
        else
        begin
            sync_1_q <= {brake_relay_feedback, switch_off_feedback, plain_input};
            sync_2_q <= sync_1_q;
        end
    end

    logic [1:0] ch_sync_1_q;
    logic [1:0] ch_sync_2_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch_sync_1_q <= 2'b00;
            ch_sync_2_q <= 2'b00;
        end
        else
        begin
            ch_sync_1_q <= dual_channel_safety_input;
            ch_sync_2_q <= ch_sync_1_q;
        end
    end

    // time base
    assign tb.us_tick = us_tick_q;
    assign tb.ms_tick = ms_tick_q;
    assign tb.s_tick = s_tick_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            us_div_q <= 7'h00;
            ms_div_q <= 10'h000;
            s_div_q <= 10'h000;
            us_tick_q <= 1'b0;
            ms_tick_q <= 1'b0;
            s_tick_q <= 1'b0;
        end
        else
        begin
            us_tick_q <= us_div_q == 7'(US_CYCLES - 1);
            us_div_q <= us_div_q == 7'(US_CYCLES - 1) ? 7'h00 : us_div_q + 7'h01;
            ms_tick_q <= us_tick_q && ms_div_q == 10'(US_PER_MS_P - 1);
            if (us_tick_q)
                ms_div_q <= ms_div_q == 10'(US_PER_MS_P - 1) ? 10'h000 : ms_div_q + 10'h001;
            s_tick_q <= ms_tick_q && s_div_q == 10'(MS_PER_S_P - 1);
            if (ms_tick_q)
                s_div_q <= s_div_q == 10'(MS_PER_S_P - 1) ? 10'h000 : s_div_q + 10'h001;
        end
    end

    // debounce: one filter per safety channel, own setting for the plain input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ch
            deb_filter u_deb (
                .clk(clk),
                .rst_n(rst_n),
                .tb(tb),
                .raw(ch_sync_2_q[gi]),
                .deb_us(safety_input_debounce_q),
                .filt(ch_filt[gi]),
                .toggle_fault(ch_toggle[gi])
            );
        end
    endgenerate

    deb_filter u_plain (
        .clk(clk),
        .rst_n(rst_n),
        .tb(tb),
        .raw(sync_2_q[1]),
        .deb_us(plain_input_debounce_q),
        .filt(plain_filt),
        .toggle_fault()
    );

    // channel agreement and selection
    assign mismatch = ch_filt[0] != ch_filt[1];
    assign mis_expire = mismatch && ms_tick_q && (mis_ms_q >= channel_mismatch_tolerance_q);
    assign any_fall = |(ch_filt_q & ~ch_filt);
    assign to_d = enabled && (any_fall || to_q ? !(ch_filt == 2'b11 && !mismatch_fault_q && !toggle_fault_q)
        : (ch_filt != 2'b11 || mismatch_fault_q || toggle_fault_q));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ch_filt_q <= 2'b00;
            mis_ms_q <= 16'h0000;
            mismatch_fault_q <= 1'b0;
            toggle_fault_q <= 1'b0;
            to_q <= 1'b0;
        end
        else
        begin
            ch_filt_q <= ch_filt;
            mis_ms_q <= !mismatch ? 16'h0000 : (ms_tick_q && mis_ms_q != 16'hffff ? mis_ms_q + 16'h0001 : mis_ms_q);
            // mismatch fault holds until acknowledged with both channels in agreement or safety disabled, toggle fault until acknowledged or disabled
            if (enabled && mis_expire)
                mismatch_fault_q <= 1'b1;
            else if (!enabled || (ack_wr && !mismatch))
                mismatch_fault_q <= 1'b0;
            if (enabled && |ch_toggle)
                toggle_fault_q <= 1'b1;
            else if (!enabled || ack_wr)
                toggle_fault_q <= 1'b0;
            to_q <= to_d;
        end
    end

    // forced self-test of the switch-off paths
    assign paths_off = sync_2_q[2] && (!brake_present_q || sync_2_q[3]);
    assign test_done = test_q == TEST_CHECK && paths_off;
    assign test_bad = test_q == TEST_CHECK && !paths_off;

    always_comb
    begin
        test_d = test_q;
        case (test_q)
            TEST_IDLE: if (enabled && to_d && !to_q) test_d = TEST_DRIVE;
            TEST_DRIVE: if (us_tick_q && test_us_q >= TEST_SETTLE_US) test_d = TEST_CHECK;
            TEST_CHECK: test_d = TEST_IDLE;
            default: test_d = TEST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            test_q <= TEST_IDLE;
            test_us_q <= 16'h0000;
            test_fail_q <= 1'b0;
        end
        else
        begin
            test_q <= test_d;
            test_us_q <= test_q != TEST_DRIVE ? 16'h0000 : test_us_q + {15'h0000, us_tick_q};
            if (test_bad)
                test_fail_q <= 1'b1;
            else if (test_done || ack_wr)
                test_fail_q <= 1'b0;
        end
    end

    selftest_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tb(tb),
        .enabled(enabled),
        .done(test_done),
        .interval(selftest_interval_q),
        .time_left(time_left),
        .request(request)
    );

    // registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            safety_enable_select_q <= ENABLE_NONE;
            safety_password_entry_q <= PASSWORD_NONE;
            commissioning_filter_q <= FILTER_READY;
            channel_mismatch_tolerance_q <= TOL_MS_RST;
            safety_input_debounce_q <= SAFE_DEB_US_RST;
            plain_input_debounce_q <= PLAIN_DEB_US_RST;
            selftest_interval_q <= INTERVAL_S_RST;
            irq_mask_q <= '0;
            brake_present_q <= 1'b0;
        end
        else
        begin
            if (wr && hit(avs_address, OFS_FILTER))
                commissioning_filter_q <= avs_writedata[7:0];
            if (wr && hit(avs_address, OFS_PLAIN_DEB))
                plain_input_debounce_q <= avs_writedata[15:0];
            if (wr && hit(avs_address, OFS_IRQ_MASK))
                irq_mask_q <= avs_writedata[IRQ_W-1:0];
            if (safety_wr && hit(avs_address, OFS_ENABLE))
                safety_enable_select_q <= avs_writedata[3:0];
            if (safety_wr && hit(avs_address, OFS_PASSWORD))
                safety_password_entry_q <= avs_writedata;
            if (safety_wr && hit(avs_address, OFS_TOL))
                channel_mismatch_tolerance_q <= avs_writedata[15:0];
            if (safety_wr && hit(avs_address, OFS_SAFE_DEB))
                safety_input_debounce_q <= avs_writedata[15:0];
            if (safety_wr && hit(avs_address, OFS_INTERVAL))
                selftest_interval_q <= avs_writedata;
            if (safety_wr && hit(avs_address, OFS_CTRL))
                brake_present_q <= avs_writedata[CTRL_BRAKE];
        end
    end

    // sticky events, write one to clear, set wins
    assign irq_set[IRQ_MISMATCH] = enabled && mis_expire;
    assign irq_set[IRQ_TOGGLE] = enabled && |ch_toggle;
    assign irq_set[IRQ_TO_SEL] = to_d && !to_q;
    assign irq_set[IRQ_REQUEST] = request && !selftest_request_flag;
    assign irq_set[IRQ_TEST_FAIL] = test_bad;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_stat_q <= '0;
        else
            irq_stat_q <= irq_set | (irq_stat_q &
                ~(wr && hit(avs_address, OFS_IRQ_STAT) ? avs_writedata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
    end

    // read mux
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            OFS_ENABLE: rdata_d[3:0] = safety_enable_select_q;
            OFS_PASSWORD: rdata_d = safety_password_entry_q;
            OFS_FILTER: rdata_d[7:0] = commissioning_filter_q;
            OFS_TOL: rdata_d[15:0] = channel_mismatch_tolerance_q;
            OFS_SAFE_DEB: rdata_d[15:0] = safety_input_debounce_q;
            OFS_PLAIN_DEB: rdata_d[15:0] = plain_input_debounce_q;
            OFS_INTERVAL: rdata_d = selftest_interval_q;
            OFS_TIME_LEFT: rdata_d = time_left;
            OFS_STATUS:
            begin
                rdata_d[ST_PW_SET] = safety_password_entry_q != PASSWORD_NONE;
                rdata_d[ST_TO_ACTIVE] = to_q;
                rdata_d[ST_MISMATCH] = mismatch_fault_q;
                rdata_d[ST_TOGGLE] = toggle_fault_q;
                rdata_d[ST_TEST_FAIL] = test_fail_q;
                rdata_d[ST_TESTING] = test_q != TEST_IDLE;
                rdata_d[ST_REQUEST] = request;
            end
            OFS_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
            OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
            OFS_CTRL: rdata_d[CTRL_BRAKE] = brake_present_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // outputs, all registered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            plain_input_filtered <= 1'b0;
            torque_off_function <= 1'b0;
            torque_off_active_flag <= 1'b0;
            selftest_request_flag <= 1'b0;
            selftest_drive <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            avs_waitrequest <= !access;
            if (access && avs_read)
                avs_readdata <= rdata_d;
            plain_input_filtered <= plain_filt;
            torque_off_function <= to_d;
            torque_off_active_flag <= to_d;
            selftest_request_flag <= request;
            selftest_drive <= test_d == TEST_DRIVE;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

// ---- dv/sensor_model.sv ----
`timescale 1ns/1ps
module sensor_model
(
    input wire logic clk,
    input wire logic [1:0] chan_cmd,
    input wire logic [1:0] glitch,
    input wire logic fb_stuck,
    input wire logic selftest_drive,
    output logic [1:0] dual_channel_safety_input,
    output logic switch_off_feedback,
    output logic brake_relay_feedback
);
    logic [3:0] fb_q = 4'h0;
    // contacts follow the command, glitch gives short bit-pattern test pulses
    assign dual_channel_safety_input = chan_cmd ^ glitch;
    // switch-off paths and brake relay confirm a few cycles after the drive
    always_ff @(posedge clk)
        fb_q <= {fb_q[2:0], selftest_drive};
    // a stuck switch-off path never confirms
    assign switch_off_feedback = fb_q[3] && !fb_stuck;
    assign brake_relay_feedback = fb_q[3];
endmodule

// ---- dv/fsi_chk.sv ----
`timescale 1ns/1ps
module fsi_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] dual_channel_safety_input,
    input wire logic plain_input,
    input wire logic plain_input_filtered,
    input wire logic torque_off_function,
    input wire logic torque_off_active_flag,
    input wire logic selftest_request_flag,
    input wire logic selftest_drive
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_flag;
        torque_off_active_flag == torque_off_function;
    endproperty
    a_flag: assert property (p_flag) else $error("active flag differs");
    property p_test_start;
        $rose(torque_off_function) |-> ##[0:2] selftest_drive;
    endproperty
    a_test_start: assert property (p_test_start) else $error("no self-test on select");
    property p_test_len;
        $rose(selftest_drive) |-> selftest_drive[*8];
    endproperty
    a_test_len: assert property (p_test_len) else $error("self-test drive too short");
    property p_test_cause;
        $rose(selftest_drive) |-> torque_off_function;
    endproperty
    a_test_cause: assert property (p_test_cause) else $error("self-test without torque-off");
    property p_hold;
        torque_off_function && dual_channel_safety_input != 2'b11 && !avs_write |=> torque_off_function;
    endproperty
    a_hold: assert property (p_hold) else $error("torque-off released early");
    property p_plain;
        $changed(plain_input_filtered) |-> $past(plain_input, 8) == plain_input_filtered;
    endproperty
    a_plain: assert property (p_plain) else $error("plain filter passed a short level");
    property p_rdata;
        $changed(avs_readdata) |-> $past(avs_read);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved without read");
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("access not completed in one cycle");
    property p_req_clear;
        $fell(selftest_request_flag) |-> $past(selftest_drive) || $past(selftest_drive, 2) ||
            $past(selftest_drive, 3) || $past(selftest_drive, 4);
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request cleared without test");
endmodule
bind failsafe_input_filter_test_timer fsi_chk u_fsi_chk (.clk, .rst_n, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .dual_channel_safety_input, .plain_input, .plain_input_filtered,
    .torque_off_function, .torque_off_active_flag, .selftest_request_flag, .selftest_drive);

// ---- dv/failsafe_input_filter_test_timer_bench.sv ----
`timescale 1ns/1ps
module failsafe_input_filter_test_timer_bench;
    import fsi_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [1:0] chan_cmd = 2'b11;
    logic [1:0] glitch = 2'b00;
    logic plain_input = 1'b1;
    logic fb_stuck = 1'b0;
    logic [31:0] avs_readdata, rdat;
    logic avs_waitrequest, switch_off_feedback, brake_relay_feedback, plain_input_filtered, irq;
    logic torque_off_function, torque_off_active_flag, selftest_request_flag, selftest_drive;
    logic [1:0] dual_channel_safety_input;
    int error_cnt = 0;
    int checked = 0;
    logic [7:0] ra [9] = '{OFS_ENABLE, OFS_PASSWORD, OFS_FILTER, OFS_TOL, OFS_SAFE_DEB, OFS_PLAIN_DEB,
        OFS_INTERVAL, OFS_TIME_LEFT, 8'hfc};
    logic [31:0] rv [9] = '{32'(ENABLE_NONE), PASSWORD_NONE, 32'(FILTER_READY), 32'(TOL_MS_RST),
        32'(SAFE_DEB_US_RST), 32'(PLAIN_DEB_US_RST), INTERVAL_S_RST, INTERVAL_S_RST, 32'h0000_0000};

    // 1 ms = 4 us and 1 s = 16 ms keep the run short
    failsafe_input_filter_test_timer #(.US_PER_MS_P(4), .MS_PER_S_P(16)) u_failsafe_input_filter_test_timer (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .dual_channel_safety_input, .plain_input, .switch_off_feedback, .brake_relay_feedback,
        .plain_input_filtered, .torque_off_function, .torque_off_active_flag, .selftest_request_flag,
        .selftest_drive, .irq);
    sensor_model u_sensor_model (.clk, .chan_cmd, .glitch, .fb_stuck, .selftest_drive, .dual_channel_safety_input,
        .switch_off_feedback, .brake_relay_feedback);

    initial
        forever #4 clk = ~clk;

    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    initial
    begin
        cyc(80000);
        error_cnt++;
        close_out;
    end

    initial
    begin
        cyc(8);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rchk(ra[i], rv[i]);
        bus(1'b1, OFS_ENABLE, 4'h1);
        rchk(OFS_ENABLE, 4'h0);
        bus(1'b1, OFS_FILTER, 8'h5f);
        bus(1'b1, OFS_PASSWORD, 32'hffff_ffff);
        rchk(OFS_PASSWORD, 32'hffff_ffff);
        rchk(OFS_STATUS, 4'h1);
        bus(1'b1, OFS_TOL, 4'h2);
        bus(1'b1, OFS_SAFE_DEB, 4'h8);
        bus(1'b1, OFS_PLAIN_DEB, 4'h4);
        bus(1'b1, OFS_INTERVAL, 4'h2);
        bus(1'b1, OFS_CTRL, 4'h2);
        // both channel filters settle high before safety is enabled
        cyc(1200);
        bus(1'b1, OFS_ENABLE, 4'h1);
        rchk(OFS_ENABLE, 4'h1);
        // two seconds without a self-test
        cyc(17000);
        chk(selftest_request_flag, 1'b1);
        rchk(OFS_TIME_LEFT, 4'h0);
        rchk(OFS_STATUS, 32'h8000_0001);
        rchk(OFS_IRQ_STAT, 4'h8);
        chk(irq, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 8'h1f);
        cyc(2);
        chk(irq, 1'b1);
        bus(1'b1, OFS_IRQ_STAT, 4'h8);
        rchk(OFS_IRQ_STAT, 4'h0);
        chk(irq, 1'b0);
        bus(1'b1, OFS_INTERVAL, 4'h3);
        // 4 us pulse against an 8 us debounce
        glitch <= 2'b01;
        cyc(500);
        glitch <= 2'b00;
        cyc(1300);
        chk(torque_off_function, 1'b0);
        chan_cmd <= 2'b10;
        cyc(850);
        chk(torque_off_function, 1'b0);
        cyc(350);
        chk(torque_off_function, 1'b1);
        chk(torque_off_active_flag, 1'b1);
        rchk(OFS_STATUS, 32'h8000_0023);
        cyc(1400);
        bus(1'b0, OFS_TIME_LEFT, 32'h0000_0000);
        chk(rdat inside {32'h0000_0002, 32'h0000_0003}, 1'b1);
        chk(selftest_request_flag, 1'b0);
        rchk(OFS_STATUS, 4'h7);
        chan_cmd <= 2'b11;
        cyc(1300);
        chk(torque_off_function, 1'b1);
        bus(1'b1, OFS_CTRL, 4'h3);
        cyc(4);
        chk(torque_off_function, 1'b0);
        rchk(OFS_STATUS, 4'h1);
        rchk(OFS_IRQ_STAT, 4'h5);
        bus(1'b1, OFS_IRQ_STAT, 4'h5);
        // 18 short edges on one channel
        repeat (9)
        begin
            glitch <= 2'b10;
            cyc(10);
            glitch <= 2'b00;
            cyc(10);
        end
        cyc(10);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rdat[ST_TOGGLE], 1'b1);
        bus(1'b1, OFS_CTRL, 4'h3);
        chk(plain_input_filtered, 1'b1);
        plain_input <= 1'b0;
        cyc(700);
        chk(plain_input_filtered, 1'b0);
        rchk(OFS_SAFE_DEB, 4'h8);
        // switch-off path never confirms: self-test must fail, edge 20 on channel 1 trips the toggle monitor
        fb_stuck <= 1'b1;
        chan_cmd <= 2'b00;
        cyc(1600);
        rchk(OFS_STATUS, 32'h0000_001b);
        bus(1'b1, OFS_ENABLE, 4'h0);
        chan_cmd <= 2'b00;
        cyc(1300);
        chk(torque_off_function, 1'b0);
        close_out;
    end
endmodule
